/* verilog/nhbi_top.v */
/*
 * Host bus interface of a network controller: slave register port
 * with acknowledge, remote DMA latch handshakes, bus request/grant,
 * multipurpose port request / upper address strobe pin, interrupt.
 * Assumes host pins are asynchronous to mclk_i and that the DMA
 * cycle clock is far slower than mclk_i.
 */
// Function
// - Selected write strobe writes addressed register
// - Selected read strobe returns addressed register
// - Acknowledge only after access is synchronised
// - Register address ignored while not selected
// - Latch output enable during remote write
// - Write acknowledge starts remote write cycle
// - Maskable interrupt on rx, tx, DMA done
// - Status register write clears pending interrupt
// - Reset halts traffic until run bit
// - Reset affects command, mask, data, transmit config
// - Internal reset done within ten cycles
// - Bus request raised when FIFO needs service
// - Long address mode: pin strobes upper address
// - Upper address strobe floats until grant
// - Short address mode: pin is port request
// - Pin floats until data configuration written
// - READY sampled in t3 for waits
// - Four clock cycle, one per wait
// - Read acknowledge starts latch refill read
`timescale 1ns/1ps
`include "nhbi_consts.vh"

module nhbi_top (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Slave register port (pins)
  input wire chip_select_n_i,
  input wire slave_write_strobe_n_i,
  input wire slave_read_strobe_n_i,
  input wire [3:0] register_select_inputs_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output wire reg_rdata_oe_o,
  output wire access_ack_n_o,
  // Remote DMA latch handshakes (pins)
  input wire latch_write_acknowledge_i,
  input wire latch_read_acknowledge_i,
  output reg latch_output_enable_n_o,
  output reg port_write_o,
  // Bus arbitration and cycle timing (pins)
  input wire master_grant_i,
  input wire ready_i,
  input wire dma_cycle_clock_i,
  output reg master_request_o,
  output reg [2:0] dma_phase_o,
  // Multipurpose pin and upper address
  output reg mp_pin_o,
  output reg mp_pin_oe_o,
  output reg [15:0] upper_addr_o,
  // Core events and status (same clock)
  input wire fifo_service_req_i,
  input wire rx_done_i,
  input wire tx_done_i,
  input wire dma_done_i,
  output reg txrx_enable_o,
  output reg core_reset_o,
  output reg [7:0] tx_config_o,
  // Interrupt
  output reg interrupt_o
);

  localparam NSYNC = 20;
  // Sync flops reset to each pin's idle level: no phantom access after reset
  localparam [NSYNC-1:0] PIN_IDLE = 20'h0_0007;
  localparam SL_IDLE = 1'b0;
  localparam SL_ACK = 1'b1;
  localparam K_LOCAL = 2'd0;
  localparam K_RWR = 2'd1;
  localparam K_RRD = 2'd2;

  // ****************************************
  // Two-flop synchronisers for all pins
  // ****************************************
  wire [NSYNC-1:0] pin_raw;
  wire [NSYNC-1:0] pin_s;
  assign pin_raw = {dma_cycle_clock_i, ready_i, master_grant_i,
                    latch_read_acknowledge_i, latch_write_acknowledge_i,
                    reg_wdata_i, register_select_inputs_i,
                    slave_read_strobe_n_i, slave_write_strobe_n_i,
                    chip_select_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_r <= PIN_IDLE[gi];
          sync_r <= PIN_IDLE[gi];
        end else begin
          meta_r <= pin_raw[gi];
          sync_r <= meta_r;
        end
      end
      assign pin_s[gi] = sync_r;
    end
  endgenerate

  wire cs_n_s = pin_s[0];
  wire wr_n_s = pin_s[1];
  wire rd_n_s = pin_s[2];
  wire [3:0] ra_s = pin_s[6:3];
  wire [7:0] wd_s = pin_s[14:7];
  wire lwack_s = pin_s[15];
  wire lrack_s = pin_s[16];
  wire grant_s = pin_s[17];
  wire ready_s = pin_s[18];
  wire dma_cycle_clock_s = pin_s[19];

  reg dma_cycle_clock_d_r;
  reg lwack_d_r;
  reg lrack_d_r;
  wire dma_cycle_clock_tick = dma_cycle_clock_s & ~dma_cycle_clock_d_r;
  wire lwack_rise = lwack_s & ~lwack_d_r;
  wire lrack_rise = lrack_s & ~lrack_d_r;

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] cmd_r;
  reg [7:0] isr_r;
  reg [7:0] imr_r;
  reg [7:0] dcr_r;
  reg [7:0] rsal_r;
  reg [7:0] rsah_r;
  reg dcr_prog_r;
  reg [3:0] rst_cnt_r;
  reg sl_state_r;
  reg sl_rd_r;
  reg rwr_pend_r;
  reg rrd_pend_r;
  reg [1:0] kind_r;
  reg ads_done_r;

  // Selected strobe in synchronised form
  function sl_strobe;
    input cs_n;
    input wr_n;
    input rd_n;
    begin
      sl_strobe = ~cs_n & (~wr_n | ~rd_n);
    end
  endfunction

  wire sl_go = (sl_state_r == SL_IDLE) && sl_strobe(cs_n_s, wr_n_s, rd_n_s);
  wire sl_wr = sl_go & ~wr_n_s;
  wire sl_rd = sl_go & wr_n_s;
  wire isr_wr = sl_wr && (ra_s == `NHBI_OFS_ISR);
  wire long_address_select = dcr_r[`NHBI_DCR_LAS];
  wire rst_busy = (rst_cnt_r != `NHBI_RST_DMA_CYCLE_CLOCK_CYC);

  // ****************************************
  // DMA cycle engine
  // ****************************************
  wire cyc_busy;
  wire cyc_done;
  wire [2:0] phase;
  wire want_remote = rwr_pend_r | rrd_pend_r;
  // Start on a bus clock edge so t1 lasts a full period
  wire cyc_start = ~cyc_busy & grant_s & master_request_o & ~rst_busy & dma_cycle_clock_tick;

  nhbi_dma_cycle u_cycle (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .tick_i(dma_cycle_clock_tick),
    .start_i(cyc_start),
    .ready_i(ready_s),
    .busy_o(cyc_busy),
    .phase_o(phase),
    .done_o(cyc_done)
  );

  // ****************************************
  // Slave access handshake
  // ****************************************
  assign access_ack_n_o = ~(sl_state_r == SL_ACK);
  assign reg_rdata_oe_o = (sl_state_r == SL_ACK) & sl_rd_r;

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sl_state_r <= SL_IDLE;
      sl_rd_r <= 1'b0;
    end else begin
      case (sl_state_r)
        SL_IDLE: if (sl_go) begin
          sl_state_r <= SL_ACK;
          sl_rd_r <= sl_rd;
        end
        // Held until the host ends the access, one ack per access
        SL_ACK: if (cs_n_s || (wr_n_s && rd_n_s)) begin
          sl_state_r <= SL_IDLE;
        end
        default: sl_state_r <= SL_IDLE;
      endcase
    end
  end

  // Read data captured once per access, address only while selected
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (sl_rd) begin
      if (ra_s == `NHBI_OFS_CMD) begin
        reg_rdata_o <= cmd_r;
      end else if (ra_s == `NHBI_OFS_ISR) begin
        reg_rdata_o <= {rst_busy, isr_r[6:0]};
      end else if (ra_s == `NHBI_OFS_RSAL) begin
        reg_rdata_o <= rsal_r;
      end else if (ra_s == `NHBI_OFS_RSAH) begin
        reg_rdata_o <= rsah_r;
      end else if (ra_s == `NHBI_OFS_TCR) begin
        reg_rdata_o <= tx_config_o;
      end else if (ra_s == `NHBI_OFS_DCR) begin
        reg_rdata_o <= dcr_r;
      end else if (ra_s == `NHBI_OFS_IMR) begin
        reg_rdata_o <= imr_r;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_r <= `NHBI_CMD_RST;
      imr_r <= `NHBI_IMR_RST;
      dcr_r <= `NHBI_DCR_RST;
      tx_config_o <= `NHBI_TCR_RST;
      rsal_r <= 8'h00;
      rsah_r <= 8'h00;
      dcr_prog_r <= 1'b0;
    end else if (sl_wr) begin
      if (ra_s == `NHBI_OFS_CMD) begin
        cmd_r <= wd_s;
      end else if (ra_s == `NHBI_OFS_RSAL) begin
        rsal_r <= wd_s;
      end else if (ra_s == `NHBI_OFS_RSAH) begin
        rsah_r <= wd_s;
      end else if (ra_s == `NHBI_OFS_TCR) begin
        tx_config_o <= wd_s;
      end else if (ra_s == `NHBI_OFS_DCR) begin
        dcr_r <= wd_s;
        dcr_prog_r <= 1'b1;
      end else if (ra_s == `NHBI_OFS_IMR) begin
        imr_r <= wd_s;
      end
    end
  end

  // Events win over a simultaneous clear-by-one
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      isr_r <= 8'h00;
      interrupt_o <= 1'b0;
    end else begin
      isr_r <= ((isr_r & ~(isr_wr ? wd_s : 8'h00))
               | {1'b0, dma_done_i, 4'h0, tx_done_i, rx_done_i})
               & `NHBI_ISR_MASK;
      interrupt_o <= |(isr_r & imr_r);
    end
  end

  // ****************************************
  // Reset progress and run gating
  // ****************************************
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_cnt_r <= 4'h0;
      core_reset_o <= 1'b1;
      txrx_enable_o <= 1'b0;
      dma_cycle_clock_d_r <= 1'b0;
      lwack_d_r <= 1'b0;
      lrack_d_r <= 1'b0;
    end else begin
      dma_cycle_clock_d_r <= dma_cycle_clock_s;
      lwack_d_r <= lwack_s;
      lrack_d_r <= lrack_s;
      if (rst_busy && dma_cycle_clock_tick) begin
        rst_cnt_r <= rst_cnt_r + 4'h1;
      end
      core_reset_o <= rst_busy;
      txrx_enable_o <= cmd_r[`NHBI_CMD_RUN] & ~cmd_r[`NHBI_CMD_STOP] & ~rst_busy;
    end
  end

  // ****************************************
  // Remote DMA latch handshakes and arbitration
  // ****************************************
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rwr_pend_r <= 1'b0;
      rrd_pend_r <= 1'b0;
      kind_r <= K_LOCAL;
      master_request_o <= 1'b0;
      latch_output_enable_n_o <= 1'b1;
      port_write_o <= 1'b0;
      dma_phase_o <= `NHBI_PH_IDLE;
    end else begin
      // New acknowledge beats the clear at cycle end
      if (lwack_rise && cmd_r[`NHBI_CMD_RWR]) begin
        rwr_pend_r <= 1'b1;
      end else if (cyc_done && kind_r == K_RWR) begin
        rwr_pend_r <= 1'b0;
      end
      if (lrack_rise && cmd_r[`NHBI_CMD_RRD]) begin
        rrd_pend_r <= 1'b1;
      end else if (cyc_done && kind_r == K_RRD) begin
        rrd_pend_r <= 1'b0;
      end
      if (cyc_start) begin
        kind_r <= rwr_pend_r ? K_RWR : (rrd_pend_r ? K_RRD : K_LOCAL);
      end
      // Request dropped during a cycle so a grant tied back re-arbitrates
      master_request_o <= ~rst_busy & ~cyc_busy & ~cyc_start & ~cyc_done
                          & (fifo_service_req_i | want_remote);
      latch_output_enable_n_o <= ~(cyc_busy && kind_r == K_RWR
                                   && phase != `NHBI_PH_T1);
      port_write_o <= cyc_busy && kind_r == K_RRD
                      && (phase == `NHBI_PH_T3 || phase == `NHBI_PH_TW);
      dma_phase_o <= phase;
    end
  end

  // ****************************************
  // Multipurpose pin: port request or upper address strobe
  // ****************************************
  wire remote_on = cmd_r[`NHBI_CMD_RWR] | cmd_r[`NHBI_CMD_RRD];

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mp_pin_o <= 1'b0;
      mp_pin_oe_o <= 1'b0;
      upper_addr_o <= 16'h0000;
      ads_done_r <= 1'b0;
    end else begin
      upper_addr_o <= {rsah_r, rsal_r};
      if (!grant_s) begin
        ads_done_r <= 1'b0;
      end else if (cyc_busy && phase == `NHBI_PH_T2) begin
        ads_done_r <= 1'b1;
      end
      if (!dcr_prog_r) begin
        mp_pin_oe_o <= 1'b0;
        mp_pin_o <= 1'b0;
      end else if (long_address_select) begin
        // Strobe once per grant, during t1 of the first cycle
        mp_pin_oe_o <= grant_s;
        mp_pin_o <= grant_s & ~ads_done_r & cyc_busy & (phase == `NHBI_PH_T1);
      end else begin
        mp_pin_oe_o <= 1'b1;
        mp_pin_o <= remote_on & ~want_remote & ~cyc_busy & ~rst_busy;
      end
    end
  end

endmodule

/* verilog/nhbi_consts.vh */
/*
 * Constants of the host bus interface: register offsets, field
 * positions, reset values, DMA cycle phases and reset timing.
 * Assumes inclusion by the bare name from files under verilog/.
 */
`ifndef NHBI_CONSTS_VH
`define NHBI_CONSTS_VH

// ****************************************
// Register offsets (4-bit register select)
// ****************************************
`define NHBI_OFS_CMD 4'h0
`define NHBI_OFS_ISR 4'h7
`define NHBI_OFS_RSAL 4'h8
`define NHBI_OFS_RSAH 4'h9
`define NHBI_OFS_TCR 4'hD
`define NHBI_OFS_DCR 4'hE
`define NHBI_OFS_IMR 4'hF

// ****************************************
// Field positions
// ****************************************
`define NHBI_CMD_STOP 0
`define NHBI_CMD_RUN 1
`define NHBI_CMD_RRD 3
`define NHBI_CMD_RWR 4
`define NHBI_ISR_RX 0
`define NHBI_ISR_TX 1
`define NHBI_ISR_DMA 6
`define NHBI_ISR_RST 7
`define NHBI_DCR_LAS 3

// ****************************************
// Reset values and interrupt status mask
// ****************************************
`define NHBI_CMD_RST 8'h01
`define NHBI_IMR_RST 8'h00
`define NHBI_DCR_RST 8'h00
`define NHBI_TCR_RST 8'h00
`define NHBI_ISR_MASK 8'h43

// ****************************************
// DMA cycle phases and reset timing
// ****************************************
`define NHBI_PH_IDLE 3'h0
`define NHBI_PH_T1 3'h1
`define NHBI_PH_T2 3'h2
`define NHBI_PH_T3 3'h3
`define NHBI_PH_TW 3'h4
`define NHBI_PH_T4 3'h5
`define NHBI_RST_DMA_CYCLE_CLOCK_CYC 4'hA

`endif

/* verilog/nhbi_dma_cycle.v */
/*
 * DMA memory cycle sequencer: t1, t2, t3, optional waits, t4,
 * one phase per rising edge of the DMA cycle clock.
 * Assumes the clock edge and READY arrive already synchronised.
 */
`timescale 1ns/1ps
`include "nhbi_consts.vh"

module nhbi_dma_cycle (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Control
  input wire tick_i,
  input wire start_i,
  input wire ready_i,
  // Status
  output wire busy_o,
  output wire [2:0] phase_o,
  output reg done_o
);

  reg [2:0] phase_r;
  reg [2:0] phase_nxt;

  assign phase_o = phase_r;
  assign busy_o = (phase_r != `NHBI_PH_IDLE);

  // ****************************************
  // Phase sequence
  // ****************************************
  always @* begin
    phase_nxt = phase_r;
    case (phase_r)
      `NHBI_PH_IDLE: if (start_i) phase_nxt = `NHBI_PH_T1;
      `NHBI_PH_T1: if (tick_i) phase_nxt = `NHBI_PH_T2;
      `NHBI_PH_T2: if (tick_i) phase_nxt = `NHBI_PH_T3;
      // READY looked at only in t3 and in each wait
      `NHBI_PH_T3, `NHBI_PH_TW: begin
        if (tick_i) phase_nxt = ready_i ? `NHBI_PH_TW : `NHBI_PH_T4;
      end
      `NHBI_PH_T4: if (tick_i) phase_nxt = `NHBI_PH_IDLE;
      default: phase_nxt = `NHBI_PH_IDLE;
    endcase
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= `NHBI_PH_IDLE;
      done_o <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      done_o <= (phase_r == `NHBI_PH_T4) && tick_i;
    end
  end

endmodule

/* test/nhbi_host_model.sv */
/* Host-side arbiter, READY source and free-running DMA cycle clock.
   Assumes wait_n_i is set by the bench while no DMA cycle runs. */
`timescale 1ns/1ps
`include "nhbi_consts.vh"
module nhbi_host_model (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Control and device status
  input wire [2:0] wait_n_i,
  input wire master_request_i,
  input wire [2:0] dma_phase_i,
  // Driven pins
  output logic master_grant_o,
  output wire ready_o,
  output logic dma_cycle_clock_o
);
  logic [1:0] req_d_r;
  logic [2:0] left_r;
  // ****************************************
  // Bus clock, arbiter, wait source
  // ****************************************
  initial dma_cycle_clock_o = 1'b0;
  // Eight mclk periods, far slower than mclk
  always #20 dma_cycle_clock_o = ~dma_cycle_clock_o;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_d_r <= 2'b00;
      master_grant_o <= 1'b0;
    end else begin
      req_d_r <= {req_d_r[0], master_request_i};
      // Lagging grant, dropped once idle with no request
      master_grant_o <= req_d_r[1] | (master_grant_o & (dma_phase_i != `NHBI_PH_IDLE));
    end
  end
  // Counted down in waits so READY falls before the final sample
  always @(negedge dma_cycle_clock_o or negedge arst_n_i) begin
    if (!arst_n_i) left_r <= 3'h0;
    else if (dma_phase_i == `NHBI_PH_IDLE) left_r <= wait_n_i;
    else if (dma_phase_i == `NHBI_PH_TW && left_r != 3'h0) left_r <= left_r - 3'h1;
  end
  assign ready_o = (left_r != 3'h0);
endmodule

/* test/nhbi_top_checker.sv */
/* Port checker for nhbi_top.
   Assumes it is bound onto nhbi_top; one clock domain. */
`timescale 1ns/1ps
`include "nhbi_consts.vh"
module nhbi_top_checker (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Watched ports
  input wire chip_select_n_i,
  input wire access_ack_n_o,
  input wire reg_rdata_oe_o,
  input wire rx_done_i,
  input wire tx_done_i,
  input wire dma_done_i,
  input wire interrupt_o,
  input wire txrx_enable_o,
  input wire core_reset_o,
  input wire latch_output_enable_n_o,
  input wire port_write_o,
  input wire [2:0] dma_phase_o,
  input wire fifo_service_req_i,
  input wire master_request_o
);
  wire ev_w = rx_done_i | tx_done_i | dma_done_i;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_ack_fall; $fell(access_ack_n_o); endsequence
  sequence s_cs_idle; chip_select_n_i [*4]; endsequence
  sequence s_ph_step; $changed(dma_phase_o); endsequence
  ack_after_sel_a: assert property (s_ack_fall |-> !$past(chip_select_n_i) &&
    !$past(chip_select_n_i, 2)) else $error("ack without settled select");
  ack_release_a: assert property (s_cs_idle |-> access_ack_n_o)
    else $error("ack held after deselect");
  rdata_oe_a: assert property (reg_rdata_oe_o |-> !access_ack_n_o)
    else $error("data driven outside ack");
  irq_cause_a: assert property ($rose(interrupt_o) |-> $past(ev_w) || $past(ev_w, 2) ||
    !$past(access_ack_n_o) || !$past(access_ack_n_o, 2)) else $error("interrupt without cause");
  run_gate_a: assert property (txrx_enable_o |-> !core_reset_o)
    else $error("traffic enabled in reset");
  latch_oe_a: assert property (!latch_output_enable_n_o |-> dma_phase_o != `NHBI_PH_IDLE)
    else $error("latch enable outside cycle");
  port_write_a: assert property (port_write_o |-> dma_phase_o inside
    {`NHBI_PH_T3, `NHBI_PH_TW}) else $error("port write off phase");
  phase_order_a: assert property (s_ph_step |-> dma_phase_o == $past(dma_phase_o) + 3'h1 ||
    ($past(dma_phase_o) == `NHBI_PH_T4 && dma_phase_o == `NHBI_PH_IDLE) ||
    ($past(dma_phase_o) == `NHBI_PH_T3 && dma_phase_o == `NHBI_PH_T4)) else $error("bad phase step");
  request_a: assert property ($rose(fifo_service_req_i) && !core_reset_o &&
    dma_phase_o == `NHBI_PH_IDLE |-> ##[1:2] master_request_o) else $error("no bus request");
endmodule
bind nhbi_top nhbi_top_checker u_chk (.mclk_i, .arst_n_i, .chip_select_n_i, .access_ack_n_o,
  .reg_rdata_oe_o, .rx_done_i, .tx_done_i, .dma_done_i, .interrupt_o, .txrx_enable_o,
  .core_reset_o, .latch_output_enable_n_o, .port_write_o, .dma_phase_o, .fifo_service_req_i,
  .master_request_o);

/* test/test_nic_host_bus_interface.sv */
/* Self-checking bench for nhbi_top with host model; checker is bound.
   Assumes the host model makes grant, READY and the DMA cycle clock. */
`timescale 1ns/1ps
`include "nhbi_consts.vh"
module test_nic_host_bus_interface;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, latch_write_acknowledge = 1'b0, latch_read_acknowledge = 1'b0, fifo = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, q;
  logic [2:0] ev = 3'h0, wait_n = 3'h0, phase;
  logic rdoe, ack_n, lat_oe_n, pwr, grant, ready, bclk, master_request, mp, mp_oe, txrx, crst, irq;
  logic oe_seen, pw_seen, mp_seen;
  logic [15:0] uaddr;
  logic [7:0] tcfg;
  int bad_count = 0, samples_checked = 0, n, i;
  logic [11:0] rv [5] = '{{`NHBI_OFS_CMD, 8'h01}, {`NHBI_OFS_IMR, 8'h00},
    {`NHBI_OFS_DCR, 8'h00}, {`NHBI_OFS_TCR, 8'h00}, {`NHBI_OFS_ISR, 8'h00}};
  // Address, write data, expected read; unmapped 0x3 reads zero
  logic [19:0] rows [7] = '{{`NHBI_OFS_RSAL, 8'h34, 8'h34}, {`NHBI_OFS_RSAH, 8'h12, 8'h12},
    {`NHBI_OFS_TCR, 8'h5a, 8'h5a}, {`NHBI_OFS_DCR, 8'h00, 8'h00}, {`NHBI_OFS_IMR, 8'h43, 8'h43},
    {4'h3, 8'hff, 8'h00}, {`NHBI_OFS_CMD, 8'h02, 8'h02}};
  logic [7:0] bits [3] = '{8'h01, 8'h02, 8'h40};
  always #2.5 mclk_i = ~mclk_i;
  nhbi_top dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .chip_select_n_i(cs_n),
    .slave_write_strobe_n_i(wr_n), .slave_read_strobe_n_i(rd_n),
    .register_select_inputs_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rdata_oe_o(rdoe), .access_ack_n_o(ack_n), .latch_write_acknowledge_i(latch_write_acknowledge),
    .latch_read_acknowledge_i(latch_read_acknowledge), .latch_output_enable_n_o(lat_oe_n), .port_write_o(pwr),
    .master_grant_i(grant), .ready_i(ready), .dma_cycle_clock_i(bclk),
    .master_request_o(master_request), .dma_phase_o(phase), .mp_pin_o(mp), .mp_pin_oe_o(mp_oe),
    .upper_addr_o(uaddr), .fifo_service_req_i(fifo), .rx_done_i(ev[0]), .tx_done_i(ev[1]),
    .dma_done_i(ev[2]), .txrx_enable_o(txrx), .core_reset_o(crst), .tx_config_o(tcfg),
    .interrupt_o(irq));
  nhbi_host_model u_host (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .wait_n_i(wait_n),
    .master_request_i(master_request), .dma_phase_i(phase), .master_grant_o(grant), .ready_o(ready),
    .dma_cycle_clock_o(bclk));
  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = ack_n;
      1: pick = (phase != `NHBI_PH_IDLE);
      2: pick = crst;
      default: pick = master_request;
    endcase
  endfunction
  // Bounded wait; also records what the DMA pins did meanwhile
  task till(input int s, input logic lvl);
    n = 0;
    while (pick(s) !== lvl) begin
      @(negedge mclk_i);
      n++;
      oe_seen |= !lat_oe_n;
      pw_seen |= pwr;
      mp_seen |= mp;
      if (n > 400) begin
        check(16'h0000, 16'h0001);
        wrap_up();
      end
    end
  endtask
  // Strobe held until ack, released, then ack release awaited
  task acc(input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cs_n <= 1'b0;
    addr <= a;
    wdata <= d;
    if (rd) rd_n <= 1'b0;
    else wr_n <= 1'b0;
    till(0, 1'b0);
    q = rdata;
    @(posedge mclk_i);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    till(0, 1'b1);
  endtask
  task meas;
    oe_seen = 1'b0;
    pw_seen = 1'b0;
    mp_seen = 1'b0;
    till(1, 1'b1);
    till(1, 1'b0);
  endtask
  task pulse(input logic [2:0] x);
    @(posedge mclk_i);
    ev <= x;
    @(posedge mclk_i);
    ev <= 3'h0;
    repeat (3) @(negedge mclk_i);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(negedge mclk_i);
    check(mp_oe, 1'b0);
    check(crst, 1'b1);
    till(2, 1'b0);
    check(n <= 90, 1'b1);
    check(txrx, 1'b0);
    for (i = 0; i < 5; i++) begin
      acc(1'b1, rv[i][11:8], 8'h00);
      check(q, rv[i][7:0]);
    end
    check(mp_oe, 1'b0);
    for (i = 0; i < 7; i++) begin
      acc(1'b0, rows[i][19:16], rows[i][15:8]);
      acc(1'b1, rows[i][19:16], 8'h00);
      check(q, rows[i][7:0]);
    end
    check(uaddr, 16'h1234);
    check(tcfg, 8'h5a);
    check(txrx, 1'b1);
    check(mp_oe, 1'b1);
    @(posedge mclk_i);
    wr_n <= 1'b0;
    addr <= `NHBI_OFS_TCR;
    wdata <= 8'hff;
    repeat (8) @(posedge mclk_i);
    wr_n <= 1'b1;
    @(negedge mclk_i);
    check(ack_n, 1'b1);
    acc(1'b1, `NHBI_OFS_TCR, 8'h00);
    check(q, 8'h5a);
    acc(1'b0, `NHBI_OFS_IMR, 8'h01);
    pulse(3'b010);
    check(irq, 1'b0);
    for (i = 0; i < 3; i++) begin
      acc(1'b0, `NHBI_OFS_IMR, bits[i]);
      pulse(3'b001 << i);
      check(irq, 1'b1);
      acc(1'b0, `NHBI_OFS_ISR, bits[i]);
      check(irq, 1'b0);
    end
    acc(1'b1, `NHBI_OFS_ISR, 8'h00);
    check(q, 8'h00);
    wait_n <= 3'h1;
    acc(1'b0, `NHBI_OFS_CMD, 8'h12);
    @(posedge mclk_i);
    latch_write_acknowledge <= 1'b1;
    meas();
    check(n, 16'd40);
    check(oe_seen, 1'b1);
    check(pw_seen, 1'b0);
    latch_write_acknowledge <= 1'b0;
    wait_n <= 3'h0;
    acc(1'b0, `NHBI_OFS_CMD, 8'h0a);
    @(posedge mclk_i);
    latch_read_acknowledge <= 1'b1;
    meas();
    check(n, 16'd32);
    check(pw_seen, 1'b1);
    check(oe_seen, 1'b0);
    latch_read_acknowledge <= 1'b0;
    repeat (2) @(negedge mclk_i);
    check(mp, 1'b1);
    acc(1'b0, `NHBI_OFS_DCR, 8'h08);
    @(negedge mclk_i);
    check(mp_oe, 1'b0);
    @(posedge mclk_i);
    fifo <= 1'b1;
    till(3, 1'b1);
    check(n <= 2, 1'b1);
    meas();
    check(mp_seen, 1'b1);
    fifo <= 1'b0;
    repeat (100) @(posedge mclk_i);
    wrap_up();
  end
endmodule
